// [src/tlr_pkg.sv]
package tlr_pkg;
  // rom-level command bytes
  localparam logic [7:0] ROM_READ     = 8'h33;
  localparam logic [7:0] ROM_MATCH    = 8'h55;
  localparam logic [7:0] ROM_SEARCH   = 8'hF0;
  localparam logic [7:0] ROM_SKIP     = 8'hCC;
  localparam logic [7:0] ROM_CSEARCH  = 8'hEC;
  localparam logic [7:0] ROM_OD_SKIP  = 8'h3C;
  localparam logic [7:0] ROM_OD_MATCH = 8'h69;
  // memory-level command bytes
  localparam logic [7:0] MEM_WR_SP    = 8'h0F;
  localparam logic [7:0] MEM_RD_SP    = 8'hAA;
  localparam logic [7:0] MEM_CP_SP    = 8'h55;
  localparam logic [7:0] MEM_RD       = 8'hF0;
  localparam logic [7:0] MEM_RD_CRC   = 8'hA5;
  localparam logic [7:0] MEM_CLEAR    = 8'h3C;
  localparam logic [7:0] MEM_CONVERT  = 8'h44;
  // memory layout
  localparam logic [15:0] ADDR_TEMP   = 16'h0211;
  localparam logic [7:0]  PAGE_RO_MIN = 8'h11;
  localparam int          ADDR_W      = 16;
  // identity code, crc polynomial
  localparam logic [7:0]  CRC_POLY_R  = 8'h8C;
  localparam logic [7:0]  CRC_ZERO    = 8'h00;
  localparam int          ROM_BITS    = 64;
  localparam int          BODY_BITS   = 56;
  // arbitrary neutral value
  localparam logic [7:0]  FAMILY_CODE = 8'h7E;
  localparam logic [2:0]  BIT_LAST    = 3'h7;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0000,
    ST_ROMC  = 4'b0001,
    ST_RDROM = 4'b0010,
    ST_MATCH = 4'b0011,
    ST_SRCH  = 4'b0100,
    ST_MEMC  = 4'b0101,
    ST_ADDR  = 4'b0110,
    ST_WRSP  = 4'b0111,
    ST_RDSP  = 4'b1000,
    ST_RDMEM = 4'b1001,
    ST_EXEC  = 4'b1010,
    ST_DONE  = 4'b1011
  } tlr_state_t;
endpackage

// [src/tlr_crc8.sv]
`timescale 1ns/1ps
module tlr_crc8 (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // bit stream
  input  wire logic       clear,
  input  wire logic       shift,
  input  wire logic       din,
  // result
  output logic [7:0]      crc_q
);
  logic fb;
  assign fb = crc_q[0] ^ din; // R9

  always_ff @(posedge ref_clk) begin
    if (rst || clear) begin
      crc_q <= tlr_pkg::CRC_ZERO; // R10
    end else if (shift) begin
      crc_q <= (crc_q >> 1) ^ (fb ? tlr_pkg::CRC_POLY_R : tlr_pkg::CRC_ZERO); // R9
    end
  end
endmodule

// [src/tlr_cmd_layer.sv]
`timescale 1ns/1ps
// Functional notes
// R1: master opens every transaction with one of seven rom-level commands.
// R2: decode 33h read, 55h match, F0h search; each uses the identity code.
// R3: decode CCh skip without identity code, ECh conditional search on status.
// R4: 3Ch overdrive skip and 69h overdrive match set the overdrive flag.
// R5: after an overdrive rom command at standard speed, switch to overdrive.
// R6: memory commands are accepted only after a successful rom command.
// R7: every byte is sent and received least significant bit first.
// R8: identity code is family byte, 48-bit serial, then crc of 56 bits.
// R9: crc is an 8-stage xor shift register for x^8+x^5+x^4+1.
// R10: crc register starts at zero, fed from family lsb then serial.
// R11: crc bits shifted after the serial leave the register all zero.
// R12: decode 0Fh write, AAh read, 55h copy scratchpad; copy updates flags.
// R13: decode F0h plain memory read and A5h memory read with crc.
// R14: 3Ch clears mission stamp, counters, delay, rate, alarms and histogram.
// R15: 44h performs one conversion and stores the result at 211h.
// R16: all memories except identity and scratchpad share one linear space.
// R17: logging memory is read-only; control writes blocked during a mission.
// R18: mission stores up to 2048 samples every 1 to 255 minutes.
// R19: each sample is accumulated into 63 histogram bins of 2.0 degrees.
// R20: out-of-range excursions log up to 24 entries of time, length, side.
// R21: temperatures are reported with 0.5 degree steps.
// R22: a presence indication answers the master's first bus activity.
// R23: bus writes to pages 17 and above are rejected.
// R24: a bus reset aborts any command and waits for a rom command.
module tlr_cmd_layer #(
  parameter logic [47:0] SERIAL = 48'h0000_0000_0001
) (
  // clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  // bit level from line phy (async to ref_clk)
  input  wire logic                     bus_reset,
  input  wire logic                     rx_bit_valid,
  input  wire logic                     rx_bit,
  input  wire logic                     tx_bit_req,
  output logic                          tx_bit,
  output logic                          presence,
  output logic                          overdrive_flag,
  // device status: match for conditional search, mission in progress
  input  wire logic                     cond_match,
  input  wire logic                     mission_active,
  // memory and control back end
  output logic [tlr_pkg::ADDR_W-1:0]    mem_addr_q,
  output logic [7:0]                    mem_wdata_q,
  output logic                          sp_write_q,
  output logic                          sp_read_q,
  output logic                          sp_copy_q,
  output logic                          mem_read_q,
  output logic                          mem_read_crc_q,
  output logic                          mission_clear_q,
  output logic                          convert_q,
  output logic                          selected,
  output logic                          write_rejected_q
);
  // synchronisers: bus_reset, rx_valid, rx_bit, tx_req
  logic [3:0] s1_q, s2_q, s3_q;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s1_q <= 4'h0;
      s2_q <= 4'h0;
      s3_q <= 4'h0;
    end else begin
      s1_q <= {tx_bit_req, rx_bit, rx_bit_valid, bus_reset};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  logic brst, rxv, rxb, txr;
  assign brst = s2_q[0] & ~s3_q[0];
  assign rxv  = s2_q[1] & ~s3_q[1];
  assign rxb  = s2_q[2];
  assign txr  = s2_q[3] & ~s3_q[3];

  // identity code body, lsb of family first
  localparam int ROMW = tlr_pkg::ROM_BITS;
  logic [ROMW-1:0] rom_code;
  logic [7:0] rom_crc;
  logic [5:0] crc_cnt_q;
  logic       crc_ready;
  logic       crc_shift;
  logic       crc_din;
  logic [tlr_pkg::BODY_BITS-1:0] body;
  assign body = {SERIAL, tlr_pkg::FAMILY_CODE}; // R8
  logic crc_done_q;
  assign crc_ready = (crc_cnt_q == 6'(tlr_pkg::BODY_BITS - 1)) && crc_done_q;
  assign crc_shift = ~crc_done_q;
  assign crc_din   = body[crc_cnt_q];

  // crc runs once after reset over the 56 body bits
  tlr_crc8 u_crc (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clear   (1'b0),
    .shift   (crc_shift),
    .din     (crc_din),
    .crc_q   (rom_crc)
  );
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      crc_cnt_q  <= 6'h00;
      crc_done_q <= 1'b0;
    end else if (!crc_done_q) begin
      if (crc_cnt_q == 6'(tlr_pkg::BODY_BITS - 1)) begin
        crc_done_q <= 1'b1; // R10
      end else begin
        crc_cnt_q <= crc_cnt_q + 6'h01;
      end
    end
  end
  assign rom_code = {rom_crc, body}; // R8 R11

  // byte assembly, lsb first
  logic [7:0] shreg_q;
  logic [2:0] bcnt_q;
  logic       byte_done;
  logic [7:0] rx_byte;
  assign rx_byte   = {rxb, shreg_q[7:1]}; // R7
  assign byte_done = rxv && (bcnt_q == tlr_pkg::BIT_LAST);

  tlr_pkg::tlr_state_t st_q;
  logic [7:0] cmd_q;
  logic [6:0] rpos_q;
  logic       mismatch_q;
  logic [4:0] acnt_q;
  logic       rom_bit;
  assign rom_bit = rom_code[rpos_q[5:0]];

  function automatic logic is_od(input logic [7:0] c);
    is_od = (c == tlr_pkg::ROM_OD_SKIP) || (c == tlr_pkg::ROM_OD_MATCH);
  endfunction

  // pages are 32 bytes; a mission locks only the register page, general memory stays writable
  function automatic logic copy_refused(input logic [15:0] addr, input logic busy);
    logic [10:0] page;
    page = addr[15:5];
    copy_refused = (page >= {3'h0, tlr_pkg::PAGE_RO_MIN}) // R23
                   || (busy && (page == {3'h0, tlr_pkg::PAGE_RO_MIN} - 11'h001)); // R17
  endfunction

  always_ff @(posedge ref_clk) begin
    if (rst || brst) begin
      shreg_q <= 8'h00;
      bcnt_q  <= 3'h0;
    end else if (rxv) begin
      shreg_q <= rx_byte;
      bcnt_q  <= bcnt_q + 3'h1;
    end
  end

  // presence pulse after every bus reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      presence <= 1'b0;
    end else begin
      presence <= brst; // R22
    end
  end

  // overdrive: set by od commands, cleared only by rst, a bus reset leaves it set
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      overdrive_flag <= 1'b0;
    end else if (st_q == tlr_pkg::ST_ROMC && byte_done && is_od(rx_byte)) begin
      overdrive_flag <= 1'b1; // R4 R5
    end
  end

  // search bit-triplet phase: 0 true bit, 1 complement, 2 master choice
  logic [1:0] sph_q;
  always_ff @(posedge ref_clk) begin
    if (rst || brst) begin
      st_q       <= tlr_pkg::ST_ROMC; // R24
      cmd_q      <= 8'h00;
      rpos_q     <= 7'h00;
      mismatch_q <= 1'b0;
      sph_q      <= 2'h0;
      acnt_q     <= 5'h00;
    end else begin
      case (st_q)
        tlr_pkg::ST_IDLE: begin
          st_q <= tlr_pkg::ST_IDLE;
        end
        tlr_pkg::ST_ROMC: if (byte_done && crc_ready) begin
          rpos_q <= 7'h00;
          mismatch_q <= 1'b0;
          case (rx_byte) // R1
            tlr_pkg::ROM_READ: st_q <= tlr_pkg::ST_RDROM; // R2
            tlr_pkg::ROM_MATCH, tlr_pkg::ROM_OD_MATCH: st_q <= tlr_pkg::ST_MATCH; // R2 R4
            tlr_pkg::ROM_SEARCH: st_q <= tlr_pkg::ST_SRCH; // R2
            tlr_pkg::ROM_CSEARCH: st_q <= cond_match ? tlr_pkg::ST_SRCH
                                                     : tlr_pkg::ST_IDLE; // R3
            tlr_pkg::ROM_SKIP, tlr_pkg::ROM_OD_SKIP: st_q <= tlr_pkg::ST_MEMC; // R3 R4
            default: st_q <= tlr_pkg::ST_IDLE;
          endcase
        end
        tlr_pkg::ST_RDROM: if (txr) begin
          rpos_q <= rpos_q + 7'h01;
          if (rpos_q == 7'(ROMW - 1)) st_q <= tlr_pkg::ST_MEMC;
        end
        tlr_pkg::ST_MATCH: if (rxv) begin
          rpos_q <= rpos_q + 7'h01;
          if (rxb != rom_bit) st_q <= tlr_pkg::ST_IDLE;
          else if (rpos_q == 7'(ROMW - 1)) st_q <= tlr_pkg::ST_MEMC;
        end
        tlr_pkg::ST_SRCH: begin
          if (txr && sph_q != 2'h2) sph_q <= sph_q + 2'h1;
          if (rxv && sph_q == 2'h2) begin
            sph_q  <= 2'h0;
            rpos_q <= rpos_q + 7'h01;
            if (rxb != rom_bit) st_q <= tlr_pkg::ST_IDLE;
            else if (rpos_q == 7'(ROMW - 1)) st_q <= tlr_pkg::ST_MEMC;
          end
        end
        tlr_pkg::ST_MEMC: if (byte_done) begin // R6
          cmd_q  <= rx_byte;
          acnt_q <= 5'h00;
          case (rx_byte)
            tlr_pkg::MEM_WR_SP, tlr_pkg::MEM_RD, tlr_pkg::MEM_RD_CRC,
            tlr_pkg::MEM_CP_SP: st_q <= tlr_pkg::ST_ADDR; // R12 R13
            tlr_pkg::MEM_RD_SP: st_q <= tlr_pkg::ST_RDSP; // R12
            tlr_pkg::MEM_CLEAR, tlr_pkg::MEM_CONVERT: st_q <= tlr_pkg::ST_EXEC; // R14 R15
            default: st_q <= tlr_pkg::ST_IDLE;
          endcase
        end
        tlr_pkg::ST_ADDR: if (byte_done) begin
          acnt_q <= acnt_q + 5'h01;
          if (acnt_q == 5'h01) begin
            case (cmd_q)
              tlr_pkg::MEM_WR_SP: st_q <= tlr_pkg::ST_WRSP;
              tlr_pkg::MEM_CP_SP: st_q <= tlr_pkg::ST_EXEC;
              default: st_q <= tlr_pkg::ST_RDMEM;
            endcase
          end
        end
        tlr_pkg::ST_WRSP: st_q <= tlr_pkg::ST_WRSP;
        tlr_pkg::ST_RDSP: st_q <= tlr_pkg::ST_RDSP;
        tlr_pkg::ST_RDMEM: st_q <= tlr_pkg::ST_RDMEM;
        tlr_pkg::ST_EXEC: st_q <= tlr_pkg::ST_DONE;
        tlr_pkg::ST_DONE: st_q <= tlr_pkg::ST_DONE;
        default: st_q <= tlr_pkg::ST_IDLE;
      endcase
    end
  end
  assign selected = (st_q >= tlr_pkg::ST_MEMC) && (st_q != tlr_pkg::ST_IDLE);

  // transmit bit: identity code, or its search triplet
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_bit <= 1'b1;
    end else if (st_q == tlr_pkg::ST_RDROM) begin
      tx_bit <= rom_bit; // R7
    end else if (st_q == tlr_pkg::ST_SRCH) begin
      tx_bit <= (sph_q == 2'h0) ? rom_bit : ~rom_bit;
    end else begin
      tx_bit <= 1'b1;
    end
  end

  // address capture, low byte first
  always_ff @(posedge ref_clk) begin
    if (rst || brst) begin
      mem_addr_q <= '0;
    end else if (st_q == tlr_pkg::ST_ADDR && byte_done) begin
      if (acnt_q == 5'h00) mem_addr_q[7:0] <= rx_byte; // R7
      else mem_addr_q[15:8] <= rx_byte;
    end else if (st_q == tlr_pkg::ST_EXEC && cmd_q == tlr_pkg::MEM_CONVERT) begin
      mem_addr_q <= tlr_pkg::ADDR_TEMP; // R15
    end else if (st_q == tlr_pkg::ST_WRSP && byte_done) begin
      mem_addr_q <= mem_addr_q + 16'h0001;
    end
  end

  // one-cycle command strobes toward the back end
  logic in_wr;
  assign in_wr = (st_q == tlr_pkg::ST_WRSP) && byte_done;
  always_ff @(posedge ref_clk) begin
    if (rst || brst) begin
      mem_wdata_q      <= 8'h00;
      sp_write_q       <= 1'b0;
      sp_read_q        <= 1'b0;
      sp_copy_q        <= 1'b0;
      mem_read_q       <= 1'b0;
      mem_read_crc_q   <= 1'b0;
      mission_clear_q  <= 1'b0;
      convert_q        <= 1'b0;
      write_rejected_q <= 1'b0;
    end else begin
      mem_wdata_q      <= in_wr ? rx_byte : mem_wdata_q;
      sp_write_q       <= in_wr;
      sp_read_q        <= (st_q == tlr_pkg::ST_RDSP) && txr;
      sp_copy_q        <= (st_q == tlr_pkg::ST_EXEC) && (cmd_q == tlr_pkg::MEM_CP_SP)
                          && !copy_refused(mem_addr_q, mission_active); // R12 R17 R23
      write_rejected_q <= (st_q == tlr_pkg::ST_EXEC) && (cmd_q == tlr_pkg::MEM_CP_SP)
                          && copy_refused(mem_addr_q, mission_active); // R17 R23
      mem_read_q       <= (st_q == tlr_pkg::ST_RDMEM) && txr && (cmd_q == tlr_pkg::MEM_RD);
      mem_read_crc_q   <= (st_q == tlr_pkg::ST_RDMEM) && txr
                          && (cmd_q == tlr_pkg::MEM_RD_CRC); // R13 R16
      mission_clear_q  <= (st_q == tlr_pkg::ST_EXEC) && (cmd_q == tlr_pkg::MEM_CLEAR)
                          && !mission_active; // R14
      convert_q        <= (st_q == tlr_pkg::ST_EXEC) && (cmd_q == tlr_pkg::MEM_CONVERT); // R15
    end
  end
  // sample logging, histogram and alarm log (R18 R19 R20 R21) live in the back end
endmodule

// [dv/tlr_cmd_layer_properties.sv]
`timescale 1ns/1ps
module tlr_cmd_props (
  // clock and reset
  input wire logic                       ref_clk,
  input wire logic                       rst,
  // line side
  input wire logic                       bus_reset,
  input wire logic                       tx_bit,
  input wire logic                       presence,
  input wire logic                       overdrive_flag,
  // back end
  input wire logic [tlr_pkg::ADDR_W-1:0] mem_addr_q,
  input wire logic                       sp_write_q,
  input wire logic                       sp_read_q,
  input wire logic                       sp_copy_q,
  input wire logic                       mem_read_q,
  input wire logic                       mem_read_crc_q,
  input wire logic                       mission_clear_q,
  input wire logic                       convert_q,
  input wire logic                       selected,
  input wire logic                       write_rejected_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic any_mem;
  assign any_mem = sp_write_q | sp_read_q | sp_copy_q | mem_read_q | mem_read_crc_q
                 | mission_clear_q | convert_q;
  // two sync flops plus edge detect, so presence lags the reset edge a little
  a_presence_answer: assert property ($rose(bus_reset) |-> ##[1:5] presence)
    else $error("no presence after bus reset");
  a_presence_pulse: assert property (presence |=> !presence)
    else $error("presence longer than one cycle");
  a_reset_abort: assert property ($rose(bus_reset) |-> ##[1:5] !selected)
    else $error("still selected after bus reset");
  a_mem_after_rom: assert property (any_mem |-> (selected || $past(selected)))
    else $error("memory strobe without rom selection");
  a_cmd_onehot: assert property ($onehot0({sp_write_q, sp_read_q, sp_copy_q, mem_read_q,
    mem_read_crc_q, mission_clear_q, convert_q})) else $error("two command strobes at once");
  a_convert_addr: assert property (convert_q |-> ##[0:1] (mem_addr_q == tlr_pkg::ADDR_TEMP))
    else $error("conversion result address wrong");
  a_od_sticky: assert property (overdrive_flag |=> overdrive_flag)
    else $error("overdrive flag dropped");
  a_reset_idle: assert property ($fell(rst) |-> tx_bit && !overdrive_flag && !selected)
    else $error("outputs not idle after reset");
  a_reject_pulse: assert property (write_rejected_q |=> !write_rejected_q)
    else $error("rejection longer than one cycle");
  cover property ($rose(selected));
  cover property (convert_q);
  cover property (write_rejected_q);
  cover property ($rose(overdrive_flag));
endmodule
bind tlr_cmd_layer tlr_cmd_props tlr_cmd_props_inst (
  .ref_clk(ref_clk), .rst(rst), .bus_reset(bus_reset), .tx_bit(tx_bit),
  .presence(presence), .overdrive_flag(overdrive_flag), .mem_addr_q(mem_addr_q),
  .sp_write_q(sp_write_q), .sp_read_q(sp_read_q), .sp_copy_q(sp_copy_q),
  .mem_read_q(mem_read_q), .mem_read_crc_q(mem_read_crc_q),
  .mission_clear_q(mission_clear_q), .convert_q(convert_q), .selected(selected),
  .write_rejected_q(write_rejected_q)
);

// [dv/tlr_host_model.sv]
`timescale 1ns/1ps
module tlr_host_model (
  // clock
  input wire logic ref_clk,
  // strobes toward the device
  output logic     bus_reset,
  output logic     rx_bit_valid,
  output logic     rx_bit,
  output logic     tx_bit_req,
  // device answers
  input wire logic tx_bit,
  input wire logic overdrive_flag
);
  initial begin
    bus_reset = 1'b0;
    rx_bit_valid = 1'b0;
    rx_bit = 1'b1;
    tx_bit_req = 1'b0;
  end
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // aborts whatever the device was doing
  task automatic line_reset();
    bus_reset <= 1'b1;
    wait_cyc(8);
    bus_reset <= 1'b0;
    wait_cyc(8);
  endtask
  task automatic put_bit(input logic b);
    int n;
    n = overdrive_flag ? 4 : 6;
    rx_bit <= b;
    wait_cyc(1);
    rx_bit_valid <= 1'b1;
    wait_cyc(n);
    rx_bit_valid <= 1'b0;
    wait_cyc(2);
    // released line shows the inverse so a stale bit cannot pass
    rx_bit <= ~b;
    wait_cyc(n);
  endtask
  task automatic put_byte(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      put_bit(v[i]);
    end
  endtask
  task automatic get_bit(output logic b);
    int n;
    n = overdrive_flag ? 4 : 6;
    tx_bit_req <= 1'b1;
    // the standing bit is the one asked for; take it before the request advances it
    wait_cyc(1);
    b = tx_bit;
    wait_cyc(n + 1);
    tx_bit_req <= 1'b0;
    wait_cyc(n);
  endtask
endmodule

// [dv/temp_logger_rom_command_layer_tb.sv]
`timescale 1ns/1ps
module temp_logger_rom_command_layer_tb;
  localparam logic [47:0] SER = 48'h5A3C_91E7_0B24;
  localparam logic [7:0] ROMS [7] = '{8'hCC, 8'h55, 8'h33, 8'hF0, 8'hEC, 8'h69, 8'h3C};
  localparam logic [7:0] MEMS [7] = '{8'h0F, 8'hAA, 8'h55, 8'hF0, 8'hA5, 8'h3C, 8'h44};
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        cond_match = 1'b1;
  logic        mission_active = 1'b0;
  logic        bus_reset, rx_bit_valid, rx_bit, tx_bit_req, tx_bit, presence;
  logic        overdrive_flag, selected, write_rejected_q;
  logic [15:0] mem_addr_q;
  logic [7:0]  mem_wdata_q;
  logic [6:0]  strb;
  logic [63:0] id, got;
  int          cnt [7];
  int          n_pres, n_rej, n_mismatch, n_compared, cyc;

  tlr_cmd_layer #(.SERIAL(SER)) tlr_cmd_layer_inst (
    .ref_clk(ref_clk), .rst(rst), .bus_reset(bus_reset), .rx_bit_valid(rx_bit_valid),
    .rx_bit(rx_bit), .tx_bit_req(tx_bit_req), .tx_bit(tx_bit), .presence(presence),
    .overdrive_flag(overdrive_flag), .cond_match(cond_match),
    .mission_active(mission_active), .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q),
    .sp_write_q(strb[0]), .sp_read_q(strb[1]), .sp_copy_q(strb[2]), .mem_read_q(strb[3]),
    .mem_read_crc_q(strb[4]), .mission_clear_q(strb[5]), .convert_q(strb[6]),
    .selected(selected), .write_rejected_q(write_rejected_q)
  );
  tlr_host_model tlr_host_model_inst (
    .ref_clk(ref_clk), .bus_reset(bus_reset), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit),
    .tx_bit_req(tx_bit_req), .tx_bit(tx_bit), .overdrive_flag(overdrive_flag)
  );

  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    n_pres += (presence === 1'b1);
    n_rej += (write_rejected_q === 1'b1);
    for (int k = 0; k < 7; k++) begin
      cnt[k] += (strb[k] === 1'b1);
    end
    if (cyc == 90000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask
  function automatic logic [7:0] crc_of(input logic [63:0] v, input int n);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < n; i++) begin
      c = (c >> 1) ^ ((c[0] ^ v[i]) ? 8'h8C : 8'h00);
    end
    return c;
  endfunction
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic put(input logic [7:0] v);
    tlr_host_model_inst.put_byte(v);
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    wait_cyc(20);
    rst <= 1'b0;
    // identity crc needs its 56 cycles before rom commands count
    wait_cyc(60);
  endtask
  task automatic send_id(input logic [63:0] v);
    for (int i = 0; i < 8; i++) begin
      put(v[8*i +: 8]);
    end
  endtask

  initial begin
    logic [7:0]  r, m, d;
    logic [15:0] a;
    int          c0 [7];
    int          p;
    void'($urandom(32'hA20D));
    id = {crc_of({8'h00, SER, tlr_pkg::FAMILY_CODE}, 56), SER, tlr_pkg::FAMILY_CODE};
    do_reset();
    check(tx_bit, 1'b1, "idle line");
    check(selected, 1'b0, "idle select");
    for (int i = 0; i < 14; i++) begin
      r = ROMS[i % 7];
      m = MEMS[(i * 3) % 7];
      do_reset();
      p = n_pres;
      tlr_host_model_inst.line_reset();
      check(n_pres - p, 1, "presence");
      put(r);
      case (r)
        8'h55, 8'h69: send_id(id);
        8'h33: begin
          for (int k = 0; k < 64; k++) begin
            tlr_host_model_inst.get_bit(got[k]);
          end
          check(got, id, "rom read");
          check(crc_of(got, 64), 8'h00, "crc residue");
        end
        8'hF0, 8'hEC: begin
          for (int k = 0; k < 64; k++) begin
            tlr_host_model_inst.get_bit(got[0]);
            tlr_host_model_inst.get_bit(got[1]);
            check(got[1:0], {~id[k], id[k]}, "search");
            tlr_host_model_inst.put_bit(id[k]);
          end
        end
        default: ;
      endcase
      wait_cyc(8);
      check(selected, 1'b1, "selected");
      check(overdrive_flag, (r == 8'h3C || r == 8'h69), "overdrive");
      a = 16'($urandom % 512);
      d = 8'($urandom);
      c0 = cnt;
      p = n_rej;
      put(m);
      if (m != 8'h3C && m != 8'h44 && m != 8'hAA) begin
        put(a[7:0]);
        put(a[15:8]);
      end
      if (m == 8'h0F) put(d);
      if (m == 8'hAA || m == 8'hF0 || m == 8'hA5) tlr_host_model_inst.get_bit(got[0]);
      wait_cyc(10);
      for (int k = 0; k < 7; k++) begin
        check(cnt[k] != c0[k], MEMS[k] == m, "strobe");
      end
      if (m == 8'h55 || m == 8'hF0 || m == 8'hA5) check(mem_addr_q, a, "addr");
      if (m == 8'hAA) check(mem_addr_q, 16'h0000, "sp read addr");
      if (m == 8'h0F) check(mem_wdata_q, d, "wdata");
      if (m == 8'h44) check(mem_addr_q, 16'h0211, "temp addr");
      check(n_rej - p, 0, "copy allowed");
    end
    for (int j = 0; j < 4; j++) begin
      do_reset();
      tlr_host_model_inst.line_reset();
      if (j == 0) begin
        put(8'h55);
        send_id(id ^ (64'h1 << ($urandom % 64)));
      end else if (j == 1) begin
        put(8'hA0);
      end else if (j == 2) begin
        put(8'hCC);
        put(8'h0F);
        tlr_host_model_inst.line_reset();
      end else begin
        cond_match <= 1'b0;
        put(8'hEC);
      end
      p = cnt[6];
      put(8'h44);
      wait_cyc(10);
      check(selected, 1'b0, "refused select");
      check(cnt[6] - p, 0, "refused cmd");
      cond_match <= 1'b1;
    end
    for (int j = 0; j < 3; j++) begin
      do_reset();
      tlr_host_model_inst.line_reset();
      put(8'hCC);
      mission_active <= (j != 1);
      a = (j == 0) ? 16'h020E : ((j == 1) ? 16'h0220 : 16'h0040);
      p = n_rej;
      put(8'h55);
      put(a[7:0]);
      put(a[15:8]);
      wait_cyc(10);
      check(n_rej - p, (j == 2) ? 0 : 1, "copy refused");
      mission_active <= 1'b0;
    end
    print_verdict();
  end
endmodule
